// ---- shared/icts_pkg.sv ----
// Constants and types for the instruction cycle timing controller
package icts_pkg;

    typedef enum logic [3:0] {
        ICTS_ALU    = 4'h0,
        ICTS_MUL    = 4'h1,
        ICTS_MULH   = 4'h2,
        ICTS_DIV    = 4'h3,
        ICTS_LOAD   = 4'h4,
        ICTS_STORE  = 4'h5,
        ICTS_ELW    = 4'h6,
        ICTS_JUMP   = 4'h7,
        ICTS_JALR   = 4'h8,
        ICTS_BRANCH = 4'h9,
        ICTS_CSR    = 4'ha,
        ICTS_FENCEI = 4'hb,
        ICTS_FP     = 4'hc
    } icts_cls_type;

    typedef enum logic [1:0] {
        ICTS_FP_ADD_MUL = 2'h0,
        ICTS_FP_MISC    = 2'h1,
        ICTS_FP_DIVSQRT = 2'h2
    } icts_fp_kind_type;

    localparam logic [5:0] BASE_CYCLES       = 6'h01;
    localparam logic [5:0] MULH_CYCLES       = 6'h05;
    localparam logic [5:0] DIV_MIN_CYCLES    = 6'h03;
    localparam logic [5:0] ELW_CYCLES        = 6'h04;
    localparam logic [5:0] SLOW_CSR_CYCLES   = 6'h04;
    localparam logic [5:0] MISALIGNED_CYCLES = 6'h02;
    localparam logic [1:0] REFILL_CYCLES     = 2'h1;
    localparam logic [4:0] FP_ADD_MUL_LATENCY = 5'h01;
    localparam logic [4:0] FP_MISC_OP_LATENCY = 5'h01;
    localparam logic [4:0] FP_DIVSQRT_LATENCY = 5'h0b;
    localparam logic [4:0] REG_ZERO          = 5'h00;

    function automatic logic icts_writes_rd(input icts_cls_type c);
        icts_writes_rd = (c != ICTS_STORE) && (c != ICTS_BRANCH) && (c != ICTS_FENCEI) && (c != ICTS_FP);
    endfunction : icts_writes_rd

    function automatic logic icts_redirects(input icts_cls_type c);
        icts_redirects = (c == ICTS_JUMP) || (c == ICTS_JALR) || (c == ICTS_FENCEI);
    endfunction : icts_redirects

endpackage : icts_pkg

// ---- rtl/icts_div_cost.sv ----
// Divider occupancy from the divisor's leading zero count
`timescale 1ns/1ps
`default_nettype none
module icts_div_cost
    import icts_pkg::*;
(
    input  wire logic [31:0] divisor,
    output logic      [5:0]  cost
);
    logic [31:0] zero_above;

    // Bit i is set when every divisor bit from 31 down to i is zero
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_run
            assign zero_above[gi] = ~|divisor[31:gi];
        end
    endgenerate

    always_comb begin
        cost = DIV_MIN_CYCLES;
        for (int i = 0; i < 32; i++) begin
            cost = cost + {5'h00, zero_above[i]};
        end
    end
endmodule : icts_div_cost
`default_nettype wire

// ---- rtl/icts_hazard.sv ----
// Decode stall decision for one snapshot of pipeline state
`timescale 1ns/1ps
`default_nettype none
module icts_hazard
    import icts_pkg::*;
(
    input  wire logic         id_v,
    input  wire icts_cls_type id_cls,
    input  wire logic [4:0]   id_rs1,
    input  wire logic [4:0]   id_rs2,
    input  wire logic [4:0]   id_rd,
    input  wire logic         ex_v,
    input  wire icts_cls_type ex_cls,
    input  wire logic [4:0]   ex_rd,
    input  wire logic [5:0]   ex_cnt,
    input  wire logic [4:0]   sb_cnt,
    input  wire logic [4:0]   sb_rd,
    output logic              stall
);
    logic ex_hit;
    logic load_use;
    logic jalr_dep;
    logic fp_dep;
    logic ex_busy;

    always_comb begin
        ex_hit   = ex_v && icts_writes_rd(ex_cls) && (ex_rd != REG_ZERO)
                   && ((ex_rd == id_rs1) || (ex_rd == id_rs2));
        // Loads have no forwarding path from execute
        load_use = ex_hit && ((ex_cls == ICTS_LOAD) || (ex_cls == ICTS_ELW));
        jalr_dep = ex_hit && (id_cls == ICTS_JALR) && (ex_rd == id_rs1);
        // Only another float op or a register match on a source or the destination waits on the unit
        fp_dep   = (sb_cnt != 5'h00) && ((id_cls == ICTS_FP) || ((sb_rd != REG_ZERO)
                   && ((sb_rd == id_rs1) || (sb_rd == id_rs2) || (sb_rd == id_rd))));
        ex_busy  = ex_v && (ex_cnt > BASE_CYCLES);
        stall    = id_v && (load_use || jalr_dep || fp_dep || ex_busy);
    end
endmodule : icts_hazard
`default_nettype wire

// ---- rtl/icts_timing_ctrl.sv ----
// Four-stage pipeline cycle timing and stall controller
`timescale 1ns/1ps
`default_nettype none
module icts_timing_ctrl
    import icts_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clk_en,
    input  wire logic             if_valid,
    input  wire icts_cls_type     if_cls,
    input  wire logic [4:0]       if_rd,
    input  wire logic [4:0]       if_rs1,
    input  wire logic [4:0]       if_rs2,
    input  wire logic             if_misaligned,
    input  wire logic             if_target_unaligned,
    input  wire logic             if_slow_csr,
    input  wire icts_fp_kind_type if_fp_kind,
    input  wire logic [31:0]      if_divisor,
    input  wire logic             ex_branch_taken,
    input  wire logic             data_wait,
    output logic                  if_ready,
    output logic                  fetch_redirect,
    output logic                  if_flush,
    output logic                  id_flush,
    output logic                  id_stall,
    output logic                  ex_busy,
    output logic                  data_req,
    output logic                  retire
);
    // Decode stage
    logic             id_v;
    icts_cls_type     id_cls;
    logic [4:0]       id_rd;
    logic [4:0]       id_rs1;
    logic [4:0]       id_rs2;
    logic             id_mis;
    logic             id_tgt;
    logic             id_slow;
    icts_fp_kind_type id_fpk;
    logic [31:0]      id_div;
    // Execute stage
    logic             ex_v;
    icts_cls_type     ex_cls;
    logic [4:0]       ex_rd;
    logic             ex_mis;
    logic             ex_tgt;
    logic [5:0]       ex_cnt;
    // Writeback stage
    logic             wb_v;
    logic [1:0]       wb_cnt;
    // Fetch refill and float scoreboard
    logic [1:0]       refill;
    logic [4:0]       sb_cnt;
    logic [4:0]       sb_rd;

    logic             next_id_v;
    icts_cls_type     next_id_cls;
    logic [4:0]       next_id_rd;
    logic [4:0]       next_id_rs1;
    logic [4:0]       next_id_rs2;
    logic             next_id_mis;
    logic             next_id_tgt;
    logic             next_id_slow;
    icts_fp_kind_type next_id_fpk;
    logic [31:0]      next_id_div;
    logic             next_ex_v;
    icts_cls_type     next_ex_cls;
    logic [4:0]       next_ex_rd;
    logic             next_ex_mis;
    logic             next_ex_tgt;
    logic [5:0]       next_ex_cnt;
    logic             next_wb_v;
    logic [1:0]       next_wb_cnt;
    logic [1:0]       next_refill;
    logic [4:0]       next_sb_cnt;
    logic [4:0]       next_sb_rd;
    logic             next_if_ready;
    logic             next_fetch_redirect;
    logic             next_if_flush;
    logic             next_id_flush;
    logic             next_id_stall;
    logic             next_ex_busy;
    logic             next_data_req;
    logic             next_retire;

    logic             stall_now;
    logic             stall_next;
    logic [5:0]       div_cost;
    logic [5:0]       id_cost;
    logic             ex_done;
    logic             id_go;
    logic             take;
    logic             br_redirect;

    icts_div_cost u_div_cost (
        .divisor (id_div),
        .cost    (div_cost)
    );

    icts_hazard u_hazard_now (
        .id_v   (id_v),
        .id_cls (id_cls),
        .id_rs1 (id_rs1),
        .id_rs2 (id_rs2),
        .id_rd  (id_rd),
        .ex_v   (ex_v),
        .ex_cls (ex_cls),
        .ex_rd  (ex_rd),
        .ex_cnt (ex_cnt),
        .sb_cnt (sb_cnt),
        .sb_rd  (sb_rd),
        .stall  (stall_now)
    );

    // Registered outputs need the stall of the coming cycle
    icts_hazard u_hazard_next (
        .id_v   (next_id_v),
        .id_cls (next_id_cls),
        .id_rs1 (next_id_rs1),
        .id_rs2 (next_id_rs2),
        .id_rd  (next_id_rd),
        .ex_v   (next_ex_v),
        .ex_cls (next_ex_cls),
        .ex_rd  (next_ex_rd),
        .ex_cnt (next_ex_cnt),
        .sb_cnt (next_sb_cnt),
        .sb_rd  (next_sb_rd),
        .stall  (stall_next)
    );

    // Execute occupancy of the instruction now in decode
    always_comb begin
        unique case (id_cls)
            ICTS_MULH: id_cost = MULH_CYCLES;
            ICTS_DIV: id_cost = div_cost;
            ICTS_ELW: id_cost = ELW_CYCLES;
            ICTS_CSR: id_cost = id_slow ? SLOW_CSR_CYCLES : BASE_CYCLES;
            ICTS_LOAD, ICTS_STORE: id_cost = id_mis ? MISALIGNED_CYCLES : BASE_CYCLES;
            // Single-cycle multiplier, integer ops, branches, jumps, float dispatch
            default: id_cost = BASE_CYCLES;
        endcase
    end

    always_comb begin
        next_id_v    = id_v;
        next_id_cls  = id_cls;
        next_id_rd   = id_rd;
        next_id_rs1  = id_rs1;
        next_id_rs2  = id_rs2;
        next_id_mis  = id_mis;
        next_id_tgt  = id_tgt;
        next_id_slow = id_slow;
        next_id_fpk  = id_fpk;
        next_id_div  = id_div;
        next_ex_v    = ex_v;
        next_ex_cls  = ex_cls;
        next_ex_rd   = ex_rd;
        next_ex_mis  = ex_mis;
        next_ex_tgt  = ex_tgt;
        next_ex_cnt  = ex_cnt;
        next_wb_v    = wb_v;
        next_wb_cnt  = wb_cnt;
        next_refill  = refill;
        next_sb_cnt  = sb_cnt;
        next_sb_rd   = sb_rd;
        next_id_flush = id_flush;
        next_retire   = retire;
        ex_done     = ex_v && (ex_cnt == BASE_CYCLES);
        br_redirect = ex_done && (ex_cls == ICTS_BRANCH) && ex_branch_taken;
        id_go       = id_v && !stall_now && !br_redirect;
        take        = if_valid && if_ready && !br_redirect;
        // A data-side wait freezes every stage so memory stalls add on
        if (!data_wait) begin
            if (sb_cnt != 5'h00) begin
                next_sb_cnt = sb_cnt - 5'h01;
            end
            if (id_go && (id_cls == ICTS_FP)) begin
                next_sb_rd = id_rd;
                unique case (id_fpk)
                    // Latency cycles of waiting, so latency independent ops hide it fully
                    ICTS_FP_ADD_MUL: next_sb_cnt = FP_ADD_MUL_LATENCY;
                    ICTS_FP_MISC: next_sb_cnt = FP_MISC_OP_LATENCY;
                    default: next_sb_cnt = FP_DIVSQRT_LATENCY;
                endcase
            end
            if (wb_v && (wb_cnt != 2'h1)) begin
                next_wb_cnt = wb_cnt - 2'h1;
            end else begin
                next_wb_v   = ex_done;
                next_wb_cnt = (ex_mis && ((ex_cls == ICTS_LOAD) || (ex_cls == ICTS_STORE))) ? 2'h2 : 2'h1;
            end
            if (ex_v && !ex_done) begin
                next_ex_cnt = ex_cnt - 6'h01;
            end else begin
                next_ex_v   = id_go;
                next_ex_cls = id_cls;
                next_ex_rd  = id_rd;
                next_ex_mis = id_mis;
                next_ex_tgt = id_tgt;
                next_ex_cnt = id_cost;
            end
            if (refill != 2'h0) begin
                next_refill = refill - 2'h1;
            end
            if (br_redirect) begin
                next_id_v   = 1'b0;
                next_refill = REFILL_CYCLES + {1'b0, ex_tgt};
            end else if (!id_v || id_go) begin
                next_id_v    = take;
                next_id_cls  = if_cls;
                next_id_rd   = if_rd;
                next_id_rs1  = if_rs1;
                next_id_rs2  = if_rs2;
                next_id_mis  = if_misaligned;
                next_id_tgt  = if_target_unaligned;
                next_id_slow = if_slow_csr;
                next_id_fpk  = if_fp_kind;
                next_id_div  = if_divisor;
            end
            if (id_go && icts_redirects(id_cls)) begin
                // Fence is a jump to its successor with the same refill
                next_refill = REFILL_CYCLES + {1'b0, id_tgt};
            end
            next_id_flush = br_redirect;
            next_retire   = next_wb_v && (next_wb_cnt == 2'h1);
        end
    end

    // Kept apart from the state logic to avoid a false loop through the next-state hazard check
    always_comb begin
        // Jump request shows while the jump sits unstalled in decode
        next_fetch_redirect = data_wait ? fetch_redirect : ((next_id_v && icts_redirects(next_id_cls) && !stall_next)
                              || br_redirect);
        next_if_flush = next_fetch_redirect;
        next_id_stall = data_wait ? id_stall : (next_id_v && stall_next);
        next_ex_busy  = data_wait ? ex_busy : (next_ex_v && (next_ex_cnt > BASE_CYCLES));
        next_if_ready = data_wait ? if_ready : ((next_refill == 2'h0)
                        && !(next_id_v && (stall_next || icts_redirects(next_id_cls))));
        // One transaction per execute cycle of a plain access, one for event load
        next_data_req = data_wait ? data_req : (next_ex_v
                        && (((next_ex_cls == ICTS_LOAD) || (next_ex_cls == ICTS_STORE))
                        || ((next_ex_cls == ICTS_ELW) && (next_ex_cnt == ELW_CYCLES))));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            id_v    <= 1'b0;
            id_cls  <= ICTS_ALU;
            id_rd   <= REG_ZERO;
            id_rs1  <= REG_ZERO;
            id_rs2  <= REG_ZERO;
            id_mis  <= 1'b0;
            id_tgt  <= 1'b0;
            id_slow <= 1'b0;
            id_fpk  <= ICTS_FP_ADD_MUL;
            id_div  <= 32'h0000_0000;
            ex_v    <= 1'b0;
            ex_cls  <= ICTS_ALU;
            ex_rd   <= REG_ZERO;
            ex_mis  <= 1'b0;
            ex_tgt  <= 1'b0;
            ex_cnt  <= BASE_CYCLES;
            wb_v    <= 1'b0;
            wb_cnt  <= 2'h1;
            refill  <= 2'h0;
            sb_cnt  <= 5'h00;
            sb_rd   <= REG_ZERO;
            if_ready       <= 1'b1;
            fetch_redirect <= 1'b0;
            if_flush       <= 1'b0;
            id_flush       <= 1'b0;
            id_stall       <= 1'b0;
            ex_busy        <= 1'b0;
            data_req       <= 1'b0;
            retire         <= 1'b0;
        end else if (clk_en) begin
            id_v    <= next_id_v;
            id_cls  <= next_id_cls;
            id_rd   <= next_id_rd;
            id_rs1  <= next_id_rs1;
            id_rs2  <= next_id_rs2;
            id_mis  <= next_id_mis;
            id_tgt  <= next_id_tgt;
            id_slow <= next_id_slow;
            id_fpk  <= next_id_fpk;
            id_div  <= next_id_div;
            ex_v    <= next_ex_v;
            ex_cls  <= next_ex_cls;
            ex_rd   <= next_ex_rd;
            ex_mis  <= next_ex_mis;
            ex_tgt  <= next_ex_tgt;
            ex_cnt  <= next_ex_cnt;
            wb_v    <= next_wb_v;
            wb_cnt  <= next_wb_cnt;
            refill  <= next_refill;
            sb_cnt  <= next_sb_cnt;
            sb_rd   <= next_sb_rd;
            if_ready       <= next_if_ready;
            fetch_redirect <= next_fetch_redirect;
            if_flush       <= next_if_flush;
            id_flush       <= next_id_flush;
            id_stall       <= next_id_stall;
            ex_busy        <= next_ex_busy;
            data_req       <= next_data_req;
            retire         <= next_retire;
        end
    end
endmodule : icts_timing_ctrl
`default_nettype wire

// ---- testbench/icts_timing_ctrl_checker.sv ----
// Port-level timing assertions for the cycle timing controller
`timescale 1ns/1ps
`default_nettype none
module icts_timing_ctrl_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic ex_branch_taken,
    input wire logic data_wait,
    input wire logic if_ready,
    input wire logic fetch_redirect,
    input wire logic if_flush,
    input wire logic id_flush,
    input wire logic id_stall,
    input wire logic ex_busy,
    input wire logic data_req,
    input wire logic retire
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire adv = clk_en && !data_wait;

    property p_flush_eq; if_flush == fetch_redirect; endproperty
    a_flush_eq: assert property (p_flush_eq) else $error("fetch flush differs from redirect");
    property p_idf_redir; id_flush |-> fetch_redirect && if_flush; endproperty
    a_idf_redir: assert property (p_idf_redir) else $error("decode flush without fetch flush");
    property p_redir_block; fetch_redirect |-> !if_ready; endproperty
    a_redir_block: assert property (p_redir_block) else $error("ready during redirect");
    property p_refill; fetch_redirect && !id_flush && adv |=> !if_ready; endproperty
    a_refill: assert property (p_refill) else $error("jump refill cycle missing");
    property p_stall_block; id_stall |-> !if_ready; endproperty
    a_stall_block: assert property (p_stall_block) else $error("ready while decode stalled");
    // Frozen cycles must not let anything retire or move
    property p_freeze;
        !adv |=> $stable({if_ready, fetch_redirect, id_flush, id_stall, ex_busy, data_req, retire});
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
    property p_br_cause; $rose(id_flush) |-> $past(ex_branch_taken); endproperty
    a_br_cause: assert property (p_br_cause) else $error("decode flush without taken branch");
    property p_idf_pulse; id_flush && adv |=> !id_flush; endproperty
    a_idf_pulse: assert property (p_idf_pulse) else $error("decode flush longer than a cycle");

    c_jump: cover property (fetch_redirect && !id_flush);
    c_branch: cover property (id_flush);
    c_busy: cover property (ex_busy);
    c_wait: cover property (data_wait && data_req);
endmodule : icts_timing_ctrl_checker

bind icts_timing_ctrl icts_timing_ctrl_checker chk_u (.clk(clk), .nrst(nrst), .clk_en(clk_en),
    .ex_branch_taken(ex_branch_taken), .data_wait(data_wait), .if_ready(if_ready),
    .fetch_redirect(fetch_redirect), .if_flush(if_flush), .id_flush(id_flush), .id_stall(id_stall),
    .ex_busy(ex_busy), .data_req(data_req), .retire(retire));
`default_nettype wire

// ---- testbench/icts_dmem_model.sv ----
// Data memory stand-in: zero wait, or one stall burst on request
`timescale 1ns/1ps
`default_nettype none
module icts_dmem_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       data_req,
    input  wire logic [3:0] stall_len,
    output logic            data_wait
);
    logic [3:0] cnt;
    logic       used;

    // Stalls only stretch the access, never shorten it
    always @(negedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
            used <= 1'b0;
            data_wait <= 1'b0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            data_wait <= 1'b1;
        end else if (data_req && stall_len != 4'h0 && !used) begin
            cnt <= stall_len - 4'h1;
            used <= 1'b1;
            data_wait <= 1'b1;
        end else begin
            data_wait <= 1'b0;
            used <= used && stall_len != 4'h0;
        end
    end
endmodule : icts_dmem_model
`default_nettype wire

// ---- testbench/icts_timing_ctrl_tb.sv ----
// Self-checking bench for the cycle timing controller
`timescale 1ns/1ps
`default_nettype none
module icts_timing_ctrl_tb
    import icts_pkg::*;
;
    logic             clk, nrst, clk_en, if_valid, ex_branch_taken;
    logic             if_misaligned, if_target_unaligned, if_slow_csr;
    icts_cls_type     if_cls;
    icts_fp_kind_type if_fp_kind;
    logic [4:0]       if_rd, if_rs1, if_rs2;
    logic [31:0]      if_divisor;
    logic [3:0]       stall_len;
    logic             data_wait, if_ready, fetch_redirect, if_flush, id_flush, id_stall, ex_busy, data_req, retire;
    int               err_total, n_tests, r_n, r_at, blk, dq, eb;

    icts_timing_ctrl dut_u (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .if_valid(if_valid), .if_cls(if_cls), .if_rd(if_rd),
        .if_rs1(if_rs1), .if_rs2(if_rs2), .if_misaligned(if_misaligned), .if_target_unaligned(if_target_unaligned),
        .if_slow_csr(if_slow_csr), .if_fp_kind(if_fp_kind), .if_divisor(if_divisor),
        .ex_branch_taken(ex_branch_taken), .data_wait(data_wait), .if_ready(if_ready),
        .fetch_redirect(fetch_redirect), .if_flush(if_flush), .id_flush(id_flush), .id_stall(id_stall),
        .ex_busy(ex_busy), .data_req(data_req), .retire(retire)
    );
    icts_dmem_model mem_u (.clk(clk), .nrst(nrst), .data_req(data_req), .stall_len(stall_len), .data_wait(data_wait));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check

    // Holds the descriptor until taken; returns with it in decode
    task automatic issue(input icts_cls_type c, input logic [4:0] rd, input logic [4:0] rs, input logic [2:0] fl);
        int n;
        if_cls = c;
        if_rd = rd;
        if_rs1 = rs;
        if_rs2 = rs;
        {if_misaligned, if_target_unaligned, if_slow_csr} = fl;
        if_valid = 1'b1;
        n = 0;
        while (if_ready !== 1'b1 && n < 60) begin
            n++;
            @(negedge clk);
        end
        if (n == 60) begin
            err_total++;
            wrap_up();
        end
        @(negedge clk);
    endtask : issue

    task automatic watch(input int len);
        {r_n, r_at, blk, dq, eb} = '0;
        for (int i = 1; i <= len; i++) begin
            if (retire === 1'b1 && r_n == 0)
                r_at = i;
            r_n += (retire === 1'b1);
            blk += (if_ready !== 1'b1);
            dq += (data_req === 1'b1);
            eb += (ex_busy === 1'b1);
            @(negedge clk);
        end
    endtask : watch

    task automatic one(input icts_cls_type c, input logic [31:0] dv, input logic [2:0] fl, input int lat, input int nd);
        if_divisor = dv;
        issue(c, 5'h1, 5'h0, fl);
        if_valid = 1'b0;
        watch(40);
        check(r_at, lat);
        check(dq, nd);
    endtask : one

    // Retire slot is two plus the execute cost, one more for a misaligned access
    task automatic t_costs();
        one(ICTS_ALU, 32'h0, 3'h0, 3, 0);
        one(ICTS_MUL, 32'h0, 3'h0, 3, 0);
        one(ICTS_MULH, 32'h0, 3'h0, 7, 0);
        check(eb, 4);
        one(ICTS_DIV, 32'h8000_0000, 3'h0, 5, 0);
        one(ICTS_DIV, 32'h0001_0000, 3'h0, 20, 0);
        one(ICTS_DIV, 32'h0, 3'h0, 37, 0);
        one(ICTS_LOAD, 32'h0, 3'h0, 3, 1);
        one(ICTS_STORE, 32'h0, 3'h4, 5, 2);
        one(ICTS_ELW, 32'h0, 3'h0, 6, 1);
        one(ICTS_CSR, 32'h0, 3'h1, 6, 0);
        one(ICTS_CSR, 32'h0, 3'h0, 3, 0);
        $display("done costs");
    endtask : t_costs

    task automatic t_jump(input icts_cls_type c, input logic [2:0] fl, input int nb);
        issue(c, 5'h0, 5'h0, fl);
        if_valid = 1'b0;
        check(fetch_redirect & if_flush, 1'b1);
        watch(8);
        check(blk, nb);
        check(r_n, 1);
        $display("done redirect");
    endtask : t_jump

    // A younger instruction sits in decode when the branch resolves
    task automatic t_branch(input logic tk, input logic [2:0] fl, input int nb);
        issue(ICTS_BRANCH, 5'h0, 5'h0, fl);
        issue(ICTS_ALU, 5'h2, 5'h0, 3'h0);
        check(if_ready, 1'b1);
        if_valid = 1'b0;
        ex_branch_taken = tk;
        @(negedge clk);
        ex_branch_taken = 1'b0;
        check(id_flush, tk);
        watch(8);
        check(blk, nb);
        check(r_n, 2 - tk);
        $display("done branch");
    endtask : t_branch

    task automatic t_hazard(input icts_cls_type c1, input icts_cls_type c2, input logic st);
        issue(c1, 5'h5, 5'h0, 3'h0);
        issue(c2, 5'h6, 5'h5, 3'h0);
        if_valid = 1'b0;
        check(id_stall, st);
        watch(10);
        check(r_n, 2);
        $display("done hazard");
    endtask : t_hazard

    task automatic t_fp(input icts_fp_kind_type k, input int gap, input int hi);
        int n;
        if_fp_kind = k;
        issue(ICTS_FP, 5'h3, 5'h0, 3'h0);
        for (int i = 0; i < gap; i++) begin
            issue(ICTS_ALU, 5'h9, 5'h8, 3'h0);
            check(id_stall, 1'b0);
        end
        issue(ICTS_ALU, 5'ha, 5'h3, 3'h0);
        if_valid = 1'b0;
        n = 0;
        while (id_stall === 1'b1 && n < 30) begin
            n++;
            @(negedge clk);
        end
        check(hi == 0 ? n == 0 : n >= 1 && n <= hi, 1'b1);
        if (n == 30) wrap_up();
        repeat (6) @(negedge clk);
        $display("done float");
    endtask : t_fp

    // Memory and enable freezes both push retire out
    task automatic t_freeze();
        stall_len = 4'h3;
        one(ICTS_LOAD, 32'h0, 3'h0, 6, 4);
        stall_len = 4'h0;
        issue(ICTS_ALU, 5'h1, 5'h0, 3'h0);
        if_valid = 1'b0;
        clk_en = 1'b0;
        repeat (2) @(negedge clk);
        clk_en = 1'b1;
        watch(8);
        check(r_at, 3);
        $display("done freeze");
    endtask : t_freeze

    initial begin
        {nrst, if_valid, ex_branch_taken, if_misaligned, if_target_unaligned, if_slow_csr} = '0;
        {if_rd, if_rs1, if_rs2, if_divisor, stall_len, err_total, n_tests} = '0;
        clk_en = 1'b1;
        if_cls = ICTS_ALU;
        if_fp_kind = ICTS_FP_ADD_MUL;
        repeat (16) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        t_costs();
        t_jump(ICTS_JUMP, 3'h0, 2);
        t_jump(ICTS_JUMP, 3'h2, 3);
        t_jump(ICTS_FENCEI, 3'h0, 2);
        t_jump(ICTS_FENCEI, 3'h2, 3);
        t_branch(1'b1, 3'h0, 1);
        t_branch(1'b1, 3'h2, 2);
        t_branch(1'b0, 3'h0, 0);
        t_hazard(ICTS_LOAD, ICTS_ALU, 1'b1);
        t_hazard(ICTS_ALU, ICTS_JALR, 1'b1);
        t_hazard(ICTS_ALU, ICTS_ALU, 1'b0);
        t_fp(ICTS_FP_DIVSQRT, 0, 12);
        t_fp(ICTS_FP_DIVSQRT, 11, 0);
        t_fp(ICTS_FP_ADD_MUL, 0, int'(FP_ADD_MUL_LATENCY) + 1);
        t_fp(ICTS_FP_MISC, int'(FP_MISC_OP_LATENCY), 0);
        t_freeze();
        wrap_up();
    end
endmodule : icts_timing_ctrl_tb
`default_nettype wire
